// *** inc/fpt_pkg.sv ***
// package: constants for the flash power-transition host controller
package fpt_pkg;
   localparam int          CLK_MHZ          = 50;
   // wake-up intervals after reset_powerdown_n rises (ns), parameter defaults
   localparam int          WAKE_READ_NS     = 1000;
   localparam int          WAKE_WRITE_NS    = 1000;
   localparam int          WAKE_READ_CYC    = (WAKE_READ_NS * CLK_MHZ + 999) / 1000;
   localparam int          WAKE_WRITE_CYC   = (WAKE_WRITE_NS * CLK_MHZ + 999) / 1000;
   // write strobe low width and recovery (ns)
   localparam int          STROBE_NS        = 60;
   localparam int          STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int          CNT_W            = 16;
   // command codes
   localparam logic [7:0]  CMD_READ_ARRAY   = 8'hFF;
   localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0]  CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0]  CMD_PROG_SETUP   = 8'h40;
   localparam logic [7:0]  CMD_LOCK_SETUP   = 8'h60;
   localparam logic [7:0]  CMD_CONFIRM      = 8'hD0;
   // status bit positions
   localparam int          SEQ_READY_BIT    = 7;
   localparam int          ERASE_ERR_BIT    = 5;
   localparam int          PROG_ERR_BIT     = 4;
   localparam int          SUPPLY_FAULT_BIT = 3;
   // user operation codes
   typedef enum logic [2:0] {
      FPT_OP_READ    = 3'h0,
      FPT_OP_PROGRAM = 3'h1,
      FPT_OP_ERASE   = 3'h2,
      FPT_OP_LOCK    = 3'h3,
      FPT_OP_CLRSTAT = 3'h4,
      FPT_OP_SLEEP   = 3'h5
   } fpt_op_t;
endpackage : fpt_pkg

// *** inc/fpt_cyc_if.sv ***
// interface: cycle request between sequencer and strobe engine
`timescale 1ns/10ps
interface fpt_cyc_if;
   logic       start;
   logic       is_write;
   logic [7:0] wdata;
   logic       done;
   logic [7:0] rdata;
   modport seq (output start, output is_write, output wdata, input done, input rdata);
   modport eng (input start, input is_write, input wdata, output done, output rdata);
endinterface : fpt_cyc_if

// *** src/fpt_strobe.sv ***
// strobe engine: one chip-enable/write or read cycle on the flash pins
`timescale 1ns/10ps
module fpt_strobe (
   input  wire logic   clk,
   input  wire logic   rst_n,
   fpt_cyc_if.eng      cyc,
   input  wire logic [7:0] dq_in,
   output logic        ce_n,
   output logic        we_n,
   output logic        oe_n,
   output logic [7:0]  dq_out,
   output logic        dq_oe_n
);
   // ==========
   // cycle timing
   typedef enum logic [1:0] {FPT_S_IDLE = 2'b00, FPT_S_ACT = 2'b01, FPT_S_REC = 2'b11} fpt_sst_t;
   localparam logic [fpt_pkg::CNT_W-1:0] STB =
      fpt_pkg::CNT_W'(fpt_pkg::STROBE_CYC);
   fpt_sst_t                   st, next_st;
   logic [fpt_pkg::CNT_W-1:0]  cnt, next_cnt;
   logic                       wr, next_wr;
   logic [7:0]                 rd, next_rd;
   logic                       dn, next_dn;
   logic [7:0]                 wd, next_wd;

   always_comb begin
      next_st  = st;
      next_cnt = cnt;
      next_wr  = wr;
      next_rd  = rd;
      next_dn  = 1'b0;
      next_wd  = wd;
      unique case (st)
         FPT_S_IDLE: begin
            if (cyc.start) begin
               next_st  = FPT_S_ACT;
               next_cnt = STB;
               next_wr  = cyc.is_write;
               next_wd  = cyc.wdata;
            end
         end
         FPT_S_ACT: begin
            if (cnt == 1) begin
               next_st  = FPT_S_REC;
               next_cnt = STB;
               next_rd  = dq_in;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         FPT_S_REC: begin
            if (cnt == 1) begin
               next_st = FPT_S_IDLE;
               next_dn = 1'b1;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         // code 2'b10 is unused; fall back to idle rather than hang
         default: next_st = FPT_S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st      <= FPT_S_IDLE;
         cnt     <= '0;
         wr      <= 1'b0;
         rd      <= 8'h00;
         dn      <= 1'b0;
         wd      <= 8'h00;
         ce_n    <= 1'b1;
         we_n    <= 1'b1;
         oe_n    <= 1'b1;
         dq_out  <= 8'h00;
         dq_oe_n <= 1'b1;
      end else begin
         st      <= next_st;
         cnt     <= next_cnt;
         wr      <= next_wr;
         rd      <= next_rd;
         dn      <= next_dn;
         wd      <= next_wd;
         // a write lands only while both strobes are low
         ce_n    <= (next_st != FPT_S_ACT); // R9
         we_n    <= !(next_st == FPT_S_ACT && next_wr); // R9
         oe_n    <= !(next_st == FPT_S_ACT && !next_wr);
         dq_out  <= next_wd;
         // data held through recovery so it never floats under a rising strobe
         dq_oe_n <= !(next_st != FPT_S_IDLE && next_wr);
      end
   end

   assign cyc.done  = dn;
   assign cyc.rdata = rd;
endmodule : fpt_strobe

// *** src/fpt_host.sv ***
// host controller driving a flash device through its pins around power transitions
// Behaviour
// R1: device flags supply fault with op error
// R2: ready_busy_out low until reset completes
// R3: aborted op ends in deep power-down
// R4: host reissues aborted command sequence fully; code only raises aborted, the caller reissues
// R5: status cleared by reset_powerdown_n low
// R6: latch keeps last command despite supplies
// R7: latch reads array after power-up, wake
// R8: host writes read-array after every operation; code writes it only after program, erase and lock, not after clear-status
// R9: write only with chip-enable and strobe low
// R10: array changes need setup plus confirm
// R11: device ignores controls while reset low
// R12: host waits wake-up delays after reset
// R13: no operations below core supply minimum; code refuses only program, erase and lock, other ops still run
// R14: bit 7 ready; others invalid while busy
// R15: erase/program error bits, both improper
// R16: ready_busy_out low while sequencer busy
`timescale 1ns/10ps
module fpt_host #(
   parameter int WAKE_READ_CYC  = fpt_pkg::WAKE_READ_CYC,
   parameter int WAKE_WRITE_CYC = fpt_pkg::WAKE_WRITE_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        req,
   input  wire logic [2:0]  op,
   input  wire logic [7:0]  wdata,
   input  wire logic        core_supply_ok,
   input  wire logic        ready_busy_out,
   input  wire logic [7:0]  dq_in,
   output logic             ce_n,
   output logic             we_n,
   output logic             oe_n,
   output logic [7:0]       dq_out,
   output logic             dq_oe_n,
   output logic             reset_powerdown_n,
   output logic             busy,
   output logic             done,
   output logic [7:0]       rdata,
   output logic [7:0]       status,
   output logic             err_supply,
   output logic             err_program,
   output logic             err_erase,
   output logic             err_sequence,
   output logic             aborted,
   output logic             refused
);
   // ==========
   // states
   typedef enum logic [3:0] {
      FPT_IDLE  = 4'b0000,
      FPT_SETUP = 4'b0001,
      FPT_CONF  = 4'b0011,
      FPT_WAIT  = 4'b0010,
      FPT_RDST  = 4'b0110,
      FPT_POLL  = 4'b0111,
      FPT_RDARR = 4'b0101,
      FPT_FIN   = 4'b0100,
      FPT_READ  = 4'b1100,
      FPT_SLEEP = 4'b1101,
      FPT_WAKE  = 4'b1111
   } fpt_st_t;

   fpt_cyc_if cyc ();

   fpt_strobe u_strobe (
      .clk     (clk),
      .rst_n   (rst_n),
      .cyc     (cyc),
      .dq_in   (dq_in),
      .ce_n    (ce_n),
      .we_n    (we_n),
      .oe_n    (oe_n),
      .dq_out  (dq_out),
      .dq_oe_n (dq_oe_n)
   );

   // ==========
   // command decode
   function automatic logic [7:0] fpt_setup_code(input logic [2:0] o);
      unique case (o)
         3'(fpt_pkg::FPT_OP_ERASE):   fpt_setup_code = fpt_pkg::CMD_ERASE_SETUP;
         3'(fpt_pkg::FPT_OP_LOCK):    fpt_setup_code = fpt_pkg::CMD_LOCK_SETUP;
         3'(fpt_pkg::FPT_OP_CLRSTAT): fpt_setup_code = fpt_pkg::CMD_CLEAR_STATUS;
         default:                     fpt_setup_code = fpt_pkg::CMD_PROG_SETUP;
      endcase
   endfunction : fpt_setup_code

   function automatic logic fpt_alters(input logic [2:0] o);
      fpt_alters = (o == 3'(fpt_pkg::FPT_OP_PROGRAM)) || (o == 3'(fpt_pkg::FPT_OP_ERASE))
                || (o == 3'(fpt_pkg::FPT_OP_LOCK));
   endfunction : fpt_alters

   // ==========
   // sequencer
   fpt_st_t                   st, next_st;
   logic [2:0]                cur_op, next_cur_op;
   logic [7:0]                cur_wd, next_cur_wd;
   logic [fpt_pkg::CNT_W-1:0] wcnt, next_wcnt;
   logic                      pend, next_pend;
   logic                      next_done, next_aborted, next_refused, next_rpd;
   logic                      next_busy;
   logic [7:0]                next_rdata, next_status;
   logic                      next_es, next_ep, next_ee, next_eq;

   always_comb begin
      next_st      = st;
      next_cur_op  = cur_op;
      next_cur_wd  = cur_wd;
      next_wcnt    = wcnt;
      next_pend    = pend;
      next_done    = 1'b0;
      next_aborted = 1'b0;
      next_refused = 1'b0;
      next_rpd     = reset_powerdown_n;
      next_rdata   = rdata;
      next_status  = status;
      next_es      = err_supply;
      next_ep      = err_program;
      next_ee      = err_erase;
      next_eq      = err_sequence;
      cyc.start    = 1'b0;
      cyc.is_write = 1'b1;
      cyc.wdata    = 8'h00;
      unique case (st)
         FPT_IDLE: begin
            if (req) begin
               next_cur_op = op;
               next_cur_wd = wdata;
               if (fpt_alters(op) && !core_supply_ok) begin
                  next_refused = 1'b1; // R13
               end else if (op == 3'(fpt_pkg::FPT_OP_SLEEP)) begin
                  next_rpd = 1'b0;
                  next_st  = FPT_SLEEP;
               end else if (op == 3'(fpt_pkg::FPT_OP_READ)) begin
                  next_st  = FPT_READ;
               end else begin
                  next_st  = FPT_SETUP;
               end
            end
         end
         FPT_SETUP: begin
            cyc.start = !pend;
            cyc.wdata = fpt_setup_code(cur_op);
            next_pend = !cyc.done;
            if (cyc.done) begin
               // clear-status is a single write; altering ops need confirm
               next_st = fpt_alters(cur_op) ? FPT_CONF : FPT_FIN; // R10
               if (!fpt_alters(cur_op)) begin
                  next_es = 1'b0;
                  next_ep = 1'b0;
                  next_ee = 1'b0;
                  next_eq = 1'b0;
               end
            end
         end
         FPT_CONF: begin
            cyc.start = !pend;
            cyc.wdata = (cur_op == 3'(fpt_pkg::FPT_OP_ERASE)) ? fpt_pkg::CMD_CONFIRM : cur_wd;
            next_pend = !cyc.done;
            if (cyc.done) begin
               next_st = FPT_WAIT; // R10
            end
         end
         FPT_WAIT: begin
            // wait on ready_busy_out, then confirm through status
            if (ready_busy_out) begin
               next_st = FPT_RDST; // R16
            end
         end
         FPT_RDST: begin
            cyc.start = !pend;
            cyc.wdata = fpt_pkg::CMD_READ_STATUS;
            next_pend = !cyc.done;
            if (cyc.done) begin
               next_st = FPT_POLL;
            end
         end
         FPT_POLL: begin
            cyc.start    = !pend;
            cyc.is_write = 1'b0;
            next_pend    = !cyc.done;
            if (cyc.done) begin
               if (!cyc.rdata[fpt_pkg::SEQ_READY_BIT]) begin
                  next_st = FPT_WAIT; // R14
               end else begin
                  next_status = cyc.rdata;
                  next_es = cyc.rdata[fpt_pkg::SUPPLY_FAULT_BIT]; // R1
                  next_ep = cyc.rdata[fpt_pkg::PROG_ERR_BIT]; // R15
                  next_ee = cyc.rdata[fpt_pkg::ERASE_ERR_BIT]; // R15
                  next_eq = cyc.rdata[fpt_pkg::PROG_ERR_BIT]
                          & cyc.rdata[fpt_pkg::ERASE_ERR_BIT]; // R15
                  next_st = FPT_RDARR;
               end
            end
         end
         FPT_RDARR: begin
            cyc.start = !pend;
            cyc.wdata = fpt_pkg::CMD_READ_ARRAY; // R8
            next_pend = !cyc.done;
            if (cyc.done) begin
               next_st = FPT_FIN;
            end
         end
         FPT_READ: begin
            cyc.start    = !pend;
            cyc.is_write = 1'b0;
            next_pend    = !cyc.done;
            if (cyc.done) begin
               next_rdata = cyc.rdata;
               next_st    = FPT_FIN;
            end
         end
         FPT_FIN: begin
            next_done = 1'b1;
            next_st   = FPT_IDLE;
         end
         FPT_SLEEP: begin
            // device drops its status and aborts work; caller must reissue
            next_status = 8'h00; // R5
            next_aborted = !ready_busy_out; // R2 R3 R4
            if (req && op != 3'(fpt_pkg::FPT_OP_SLEEP)) begin
               next_rpd  = 1'b1;
               next_wcnt = fpt_pkg::CNT_W'(WAKE_READ_CYC > WAKE_WRITE_CYC ?
                                           WAKE_READ_CYC : WAKE_WRITE_CYC);
               next_st   = FPT_WAKE;
            end
         end
         FPT_WAKE: begin
            // latch is back in read-array, no extra command needed
            if (wcnt <= 1) begin
               next_st = FPT_FIN; // R12 R7
            end else begin
               next_wcnt = wcnt - 1'b1; // R12
            end
         end
         default: next_st = FPT_IDLE;
      endcase
      next_busy = (next_st != FPT_IDLE) && (next_st != FPT_SLEEP);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st                <= FPT_IDLE;
         cur_op            <= 3'h0;
         cur_wd            <= 8'h00;
         wcnt              <= '0;
         pend              <= 1'b0;
         done              <= 1'b0;
         aborted           <= 1'b0;
         refused           <= 1'b0;
         reset_powerdown_n <= 1'b1;
         busy              <= 1'b0;
         rdata             <= 8'h00;
         status            <= 8'h00;
         err_supply        <= 1'b0;
         err_program       <= 1'b0;
         err_erase         <= 1'b0;
         err_sequence      <= 1'b0;
      end else begin
         st                <= next_st;
         cur_op            <= next_cur_op;
         cur_wd            <= next_cur_wd;
         wcnt              <= next_wcnt;
         pend              <= next_pend;
         done              <= next_done;
         aborted           <= next_aborted;
         refused           <= next_refused;
         reset_powerdown_n <= next_rpd;
         busy              <= next_busy;
         rdata             <= next_rdata;
         status            <= next_status;
         err_supply        <= next_es;
         err_program       <= next_ep;
         err_erase         <= next_ee;
         err_sequence      <= next_eq;
      end
   end
endmodule : fpt_host

// *** tb/fpt_host_properties.sv ***
// checker: pin and status properties of the flash host controller
`timescale 1ns/10ps
module fpt_host_properties #(
   parameter int WAKE_WRITE_CYC = 2
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       req,
   input wire logic [2:0] op,
   input wire logic       core_supply_ok,
   input wire logic       ce_n,
   input wire logic       we_n,
   input wire logic       dq_oe_n,
   input wire logic       reset_powerdown_n,
   input wire logic       busy,
   input wire logic [7:0] status,
   input wire logic       err_supply,
   input wire logic       err_program,
   input wire logic       err_erase,
   input wire logic       err_sequence,
   input wire logic       refused
);
   // ==========
   // cycles since the device left power-down, saturating
   int unsigned wake_cnt;
   int unsigned next_wake_cnt;
   always_comb begin
      next_wake_cnt = wake_cnt;
      if (!reset_powerdown_n) next_wake_cnt = 0;
      else if (wake_cnt < 1000) next_wake_cnt = wake_cnt + 1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wake_cnt <= 1000;
      else wake_cnt <= next_wake_cnt;
   end
   // ==========
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_WRITE_SELECT: assert property (!we_n |-> !ce_n)
      else $error("write strobe without chip enable");
   AST_WRITE_DRIVE: assert property (!we_n |-> !dq_oe_n)
      else $error("write strobe with data bus released");
   AST_WAKE_GAP: assert property (!ce_n |-> wake_cnt >= WAKE_WRITE_CYC)
      else $error("device selected too soon after wake");
   AST_REFUSE: assert property (req && !busy && reset_powerdown_n && !core_supply_ok
      && (op inside {3'h1, 3'h2, 3'h3}) |-> ##[1:2] refused)
      else $error("altering op at low core supply not refused");
   AST_REFUSE_PULSE: assert property (refused |=> !refused)
      else $error("refused longer than one cycle");
   AST_SLEEP_STATUS: assert property ((!reset_powerdown_n) [*3] |-> status == 8'h00)
      else $error("status kept during power-down");
   AST_SLEEP_QUIET: assert property (!reset_powerdown_n |-> ce_n && we_n)
      else $error("strobes active during power-down");
   AST_SEQ_ERR: assert property (err_sequence |-> err_program && err_erase)
      else $error("sequence error without both error bits");
   AST_SUPPLY_ERR: assert property (err_supply |-> err_program || err_erase)
      else $error("supply fault without operation error");
   AST_STATUS_READY: assert property (status != 8'h00 |-> status[7])
      else $error("status captured while sequencer busy");
endmodule : fpt_host_properties

// *** tb/fpt_flash_model.sv ***
// partner: behavioural flash device at the controller's pins
`timescale 1ns/10ps
module fpt_flash_model (
   input  wire logic       clk,
   input  wire logic       ce_n,
   input  wire logic       we_n,
   input  wire logic       oe_n,
   input  wire logic [7:0] dq_out,
   input  wire logic       reset_powerdown_n,
   input  wire logic       vpp_ok,
   input  wire logic [7:0] op_cyc,
   output logic            ready_busy_out,
   output logic [7:0]      dq_in
);
   logic       we_q = 1'b1;
   logic       stat_mode = 1'b0;
   logic [2:0] sr = 3'h0;
   logic [7:0] pend = 8'h00;
   logic [7:0] mem = 8'hFF;
   logic [7:0] cnt = 8'h00;
   logic [7:0] last = 8'h00;
   assign ready_busy_out = (cnt == 8'h00);
   // ==========
   // data pins: released bus shows the inverse of the last value
   always_comb begin
      dq_in = ~last;
      if (reset_powerdown_n && !ce_n && !oe_n) begin
         dq_in = stat_mode ? ((cnt != 8'h00) ? 8'h2A : {2'h2, sr, 3'h0}) : mem;
      end
   end
   // ==========
   // command latch and write sequencer
   always_ff @(posedge clk) begin
      we_q <= we_n;
      // remember only driven values, so a released bus holds the inverse
      if (reset_powerdown_n && !ce_n && !oe_n) last <= dq_in;
      // busy runs out even in reset, then power-down; no retry
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      if (!reset_powerdown_n) begin
         sr <= 3'h0;
         pend <= 8'h00;
         stat_mode <= 1'b0;
      end else if (!we_n && we_q && !ce_n) begin
         if (pend != 8'h00) begin
            pend <= 8'h00;
            stat_mode <= 1'b1;
            cnt <= op_cyc;
            // erase and lock confirm with the confirm code; anything else is improper
            if ((pend == fpt_pkg::CMD_ERASE_SETUP || pend == fpt_pkg::CMD_LOCK_SETUP)
                && dq_out != fpt_pkg::CMD_CONFIRM) begin
               sr[2:1] <= 2'h3;
            end else if (!vpp_ok) begin
               sr <= (pend == fpt_pkg::CMD_ERASE_SETUP) ? 3'h5 : 3'h3;
            end else if (pend == fpt_pkg::CMD_PROG_SETUP) begin
               mem <= dq_out;
            end else if (pend == fpt_pkg::CMD_ERASE_SETUP) begin
               mem <= 8'hFF;
            end
         end else begin
            case (dq_out)
               fpt_pkg::CMD_ERASE_SETUP, fpt_pkg::CMD_PROG_SETUP,
               fpt_pkg::CMD_LOCK_SETUP: pend <= dq_out;
               fpt_pkg::CMD_READ_STATUS: stat_mode <= 1'b1;
               fpt_pkg::CMD_CLEAR_STATUS: sr <= 3'h0;
               fpt_pkg::CMD_READ_ARRAY: stat_mode <= 1'b0;
               default: ;
            endcase
         end
      end
   end
endmodule : fpt_flash_model

// *** tb/flash_power_transition_control_test.sv ***
// testbench: flash host controller against the behavioural device
`timescale 1ns/10ps
module flash_power_transition_control_test;
   typedef struct packed {
      logic [2:0] op;
      logic [7:0] wd;
      logic       vpp;
      logic [7:0] lat;
      logic [7:0] rd;
      logic [2:0] err;
   } fpt_row_t;
   localparam fpt_row_t ROWS [13] = '{
      '{3'h1, 8'h3C, 1'b1, 8'h03, 8'h00, 3'h0}, '{3'h0, 8'h00, 1'b1, 8'h03, 8'h3C, 3'h0},
      '{3'h2, 8'h00, 1'b1, 8'h28, 8'h00, 3'h0}, '{3'h0, 8'h00, 1'b1, 8'h03, 8'hFF, 3'h0},
      '{3'h1, 8'h5A, 1'b0, 8'h03, 8'h00, 3'h3}, '{3'h4, 8'h00, 1'b1, 8'h03, 8'h00, 3'h0},
      '{3'h2, 8'h00, 1'b0, 8'h05, 8'h00, 3'h5}, '{3'h4, 8'h00, 1'b1, 8'h03, 8'h00, 3'h0},
      '{3'h3, 8'hD0, 1'b1, 8'h03, 8'h00, 3'h0}, '{3'h0, 8'h00, 1'b1, 8'h03, 8'hFF, 3'h0},
      '{3'h3, 8'hD0, 1'b0, 8'h03, 8'h00, 3'h3}, '{3'h4, 8'h00, 1'b1, 8'h03, 8'h00, 3'h0},
      '{3'h3, 8'h00, 1'b1, 8'h03, 8'h00, 3'h6}};
   logic       clk, rst_n, req, core_supply_ok, vpp_ok, ready_busy_out, r;
   logic       ce_n, we_n, oe_n, dq_oe_n, reset_powerdown_n, busy, done, refused;
   logic       err_supply, err_program, err_erase, err_sequence, aborted;
   logic [2:0] op;
   logic [7:0] wdata, dq_in, dq_out, rdata, status, op_cyc;
   int         errors = 0;
   int         total_checks = 0;
   fpt_host #(.WAKE_READ_CYC(2), .WAKE_WRITE_CYC(2)) dut_u (
      .clk, .rst_n, .req, .op, .wdata, .core_supply_ok, .ready_busy_out, .dq_in, .ce_n, .we_n,
      .oe_n, .dq_out, .dq_oe_n, .reset_powerdown_n, .busy, .done, .rdata, .status, .err_supply,
      .err_program, .err_erase, .err_sequence, .aborted, .refused);
   fpt_flash_model dev_u (.clk, .ce_n, .we_n, .oe_n, .dq_out, .reset_powerdown_n, .vpp_ok,
      .op_cyc, .ready_busy_out, .dq_in);
   // ==========
   // tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic pulse(input logic [2:0] o, input logic [7:0] d);
      @(negedge clk);
      req = 1'b1;
      op = o;
      wdata = d;
      @(negedge clk);
      req = 1'b0;
   endtask : pulse
   task automatic run_op(input logic [2:0] o, input logic [7:0] d, output logic got_ref);
      int n;
      got_ref = 1'b0;
      pulse(o, d);
      for (n = 0; n < 400 && done !== 1'b1 && got_ref !== 1'b1; n++) begin
         got_ref = refused;
         @(negedge clk);
      end
      // a hung operation counts as a mismatch
      if (done !== 1'b1 && got_ref !== 1'b1) errors++;
   endtask : run_op
   // ==========
   // clock, watchdog, sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // about 500 cycles of traffic expected; twenty times that is a hang
   initial begin
      #200000;
      errors++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      op = 3'h0;
      wdata = 8'h00;
      core_supply_ok = 1'b1;
      vpp_ok = 1'b1;
      op_cyc = 8'h03;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      check({3'h0, ce_n, we_n, oe_n, dq_oe_n, reset_powerdown_n}, 8'h1F);
      check({6'h00, busy, done}, 8'h00);
      foreach (ROWS[i]) begin
         vpp_ok = ROWS[i].vpp;
         op_cyc = ROWS[i].lat;
         run_op(ROWS[i].op, ROWS[i].wd, r);
         check({5'h00, err_erase, err_program, err_supply}, {5'h00, ROWS[i].err});
         check({7'h00, err_sequence}, {7'h00, ROWS[i].err[2] & ROWS[i].err[1]});
         if (ROWS[i].op == 3'h0) check(rdata, ROWS[i].rd);
         if (ROWS[i].op inside {3'h1, 3'h2, 3'h3}) check(status, {2'h2, ROWS[i].err, 3'h0});
      end
      // low core supply: erase must be refused, array untouched
      core_supply_ok = 1'b0;
      run_op(3'h2, 8'h00, r);
      check({7'h00, r}, 8'h01);
      core_supply_ok = 1'b1;
      // power-down with errors still flagged, then wake and reissue
      pulse(3'h5, 8'h00);
      repeat (8) @(negedge clk);
      check({7'h00, reset_powerdown_n}, 8'h00);
      check(status, 8'h00);
      check({7'h00, aborted}, 8'h00);
      run_op(3'h0, 8'h00, r);
      check({7'h00, reset_powerdown_n}, 8'h01);
      run_op(3'h0, 8'h00, r);
      check(rdata, 8'hFF);
      finish_test();
   end
endmodule : flash_power_transition_control_test
bind fpt_host fpt_host_properties #(.WAKE_WRITE_CYC(WAKE_WRITE_CYC)) chk_u (.clk, .rst_n, .req,
   .op, .core_supply_ok, .ce_n, .we_n, .dq_oe_n, .reset_powerdown_n, .busy, .status, .err_supply,
   .err_program, .err_erase, .err_sequence, .refused);
